/* sfr_host.sv */
`timescale 1ns/1ps
module sfr_host #(
   parameter int HALF = sfr_pkg::SFR_SCLK_HALF,
   parameter int DUMMY = sfr_pkg::SFR_DUMMY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [31:0] address,
   input wire logic [15:0] byte_count,
   input sfr_pkg::sfr_proto_e proto,
   input wire logic four_byte_mode,
   output logic busy,
   output logic refused,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   sfr_if.host link
);
   import sfr_pkg::*;

   typedef enum logic [2:0] {
      SFR_H_IDLE, SFR_H_CMD, SFR_H_ADDR, SFR_H_DUMMY, SFR_H_DATA, SFR_H_TAIL, SFR_H_GAP
   } sfr_host_state_e;

   sfr_host_state_e state;
   sfr_cmd_s cmd;
   sfr_cmd_s dec;
   logic [7:0] ph;
   logic sclk;
   logic cs_n;
   logic mid;
   logic tick;
   logic rise_t;
   logic fall_t;
   logic [3:0] lsync1;
   logic [3:0] lsync2;
   logic [31:0] cmdsh;
   logic [31:0] addrsh;
   logic [5:0] cnt;
   logic [15:0] left;
   logic [7:0] rxsh;
   logic [31:0] rx_next;
   logic skip;
   logic [3:0] drive;
   logic [3:0] en;

   always_comb begin
      dec = sfr_decode(opcode, proto, four_byte_mode);
      mid = ph == 8'(HALF / 2 - 1);
      tick = ph == 8'(HALF - 1);
      rise_t = tick & ~sclk;
      fall_t = tick & sclk;
      rx_next = sfr_shift_in({24'h000000, rxsh}, cmd.dq1 ? {3'h0, lsync2[1]} : lsync2, cmd.dw);
   end

   assign busy = state != SFR_H_IDLE;
   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign link.host_drive = drive;
   assign link.host_en = en;

   ////////////////////////////////////////////////////////////////////////////
   // Serial clock divider and lane synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph <= 8'h00;
         sclk <= 1'b0;
         lsync1 <= 4'h0;
         lsync2 <= 4'h0;
      end else if (ce) begin
         lsync1 <= link.data_lanes;
         lsync2 <= lsync1;
         ph <= (state == SFR_H_IDLE || tick) ? 8'h00 : ph + 8'h01;
         if (tick && (state inside {SFR_H_CMD, SFR_H_ADDR, SFR_H_DUMMY, SFR_H_DATA})) begin
            sclk <= ~sclk;
         end else if (tick && state == SFR_H_TAIL) begin
            sclk <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= SFR_H_IDLE;
         cmd <= '0;
         cs_n <= 1'b1;
         cmdsh <= 32'h00000000;
         addrsh <= 32'h00000000;
         cnt <= 6'h00;
         left <= 16'h0000;
         rxsh <= 8'h00;
         skip <= 1'b0;
         drive <= 4'h0;
         en <= 4'h0;
         refused <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         done <= 1'b0;
      end else if (ce) begin
         refused <= 1'b0;
         rd_valid <= 1'b0;
         done <= 1'b0;
         unique case (state)
            SFR_H_IDLE: begin
               if (start && (!dec.ok || byte_count == 16'h0000)) begin
                  refused <= 1'b1;
               end else if (start) begin
                  cmd <= dec;
                  cmdsh <= {opcode, 24'h000000};
                  addrsh <= dec.four ? address : {address[23:0], 8'h00};
                  left <= byte_count;
                  cnt <= 6'h00;
                  cs_n <= 1'b0;
                  state <= SFR_H_CMD;
               end
            end
            SFR_H_CMD: begin
               if (mid && !sclk) begin
                  drive <= sfr_top(cmdsh, cmd.cw);
                  en <= sfr_mask(cmd.cw);
                  cmdsh <= cmdsh << cmd.cw;
               end
               if (rise_t) begin
                  cnt <= cnt + {3'h0, cmd.cw};
                  if (cnt + {3'h0, cmd.cw} == SFR_CMD_BITS) begin
                     cnt <= 6'h00;
                     state <= SFR_H_ADDR;
                  end
               end
            end
            SFR_H_ADDR: begin
               if (mid && (!sclk || cmd.dtr)) begin
                  drive <= sfr_top(addrsh, cmd.aw);
                  en <= sfr_mask(cmd.aw);
                  addrsh <= addrsh << cmd.aw;
               end
               if (rise_t || (cmd.dtr && fall_t)) begin
                  cnt <= cnt + {3'h0, cmd.aw};
                  if (cnt + {3'h0, cmd.aw} == (cmd.four ? SFR_ADDR4_BITS : SFR_ADDR3_BITS)) begin
                     cnt <= 6'h00;
                     skip <= cmd.dtr;
                     state <= cmd.dummy ? SFR_H_DUMMY : SFR_H_DATA;
                  end
               end
            end
            SFR_H_DUMMY: begin
               if (mid) begin
                  en <= 4'h0;
               end
               if (rise_t) begin
                  cnt <= cnt + 6'h01;
                  if (cnt + 6'h01 == 6'(DUMMY)) begin
                     cnt <= 6'h00;
                     state <= SFR_H_DATA;
                  end
               end
            end
            SFR_H_DATA: begin
               if (mid) begin
                  en <= 4'h0;
               end
               if (skip && fall_t) begin
                  skip <= 1'b0;
               end else if (rise_t || (cmd.dtr && fall_t)) begin
                  rxsh <= rx_next[7:0];
                  cnt <= cnt + {3'h0, cmd.dw};
                  if (cnt + {3'h0, cmd.dw} == SFR_BYTE_BITS) begin
                     cnt <= 6'h00;
                     rd_valid <= 1'b1;
                     rd_data <= rx_next[7:0];
                     left <= left - 16'h0001;
                     if (left == 16'h0001) begin
                        state <= SFR_H_TAIL;
                     end
                  end
               end
            end
            SFR_H_TAIL: begin
               if (tick && !sclk) begin
                  cs_n <= 1'b1;
                  state <= SFR_H_GAP;
               end
            end
            SFR_H_GAP: begin
               if (tick) begin
                  done <= 1'b1;
                  state <= SFR_H_IDLE;
               end
            end
         endcase
      end
   end

endmodule

/* sfr_pkg.sv */
// Behaviour
// - Select low, opcode, three or four address bytes, data
// - Single-rate address bits sampled on serial clock rise
// - Address advances after every byte sent
// - Select high stops output and aborts
// - Four-byte opcodes always take four bytes
// - Double-rate opcodes for the five fast reads
// - Extended protocol lane use per command
// - Dual protocol: fast, dual output, dual I/O
// - Quad protocol: fast, quad output, quad I/O
// - Same four-byte, double-rate and dummy rules under every protocol
// - Fast reads insert dummy clocks, read none
// - Single-rate address clock counts per protocol
// - Double-rate address uses both clock edges
// - Legacy opcodes follow configured address mode
package sfr_pkg;

   localparam logic [7:0] SFR_OP_READ = 8'h03;
   localparam logic [7:0] SFR_OP_READ4 = 8'h13;
   localparam logic [7:0] SFR_OP_FAST = 8'h0B;
   localparam logic [7:0] SFR_OP_FAST4 = 8'h0C;
   localparam logic [7:0] SFR_OP_FAST_DTR = 8'h0D;
   localparam logic [7:0] SFR_OP_DOUT = 8'h3B;
   localparam logic [7:0] SFR_OP_DOUT4 = 8'h3C;
   localparam logic [7:0] SFR_OP_DOUT_DTR = 8'h3D;
   localparam logic [7:0] SFR_OP_DIO = 8'hBB;
   localparam logic [7:0] SFR_OP_DIO4 = 8'hBC;
   localparam logic [7:0] SFR_OP_DIO_DTR = 8'hBD;
   localparam logic [7:0] SFR_OP_QOUT = 8'h6B;
   localparam logic [7:0] SFR_OP_QOUT4 = 8'h6C;
   localparam logic [7:0] SFR_OP_QOUT_DTR = 8'h6D;
   localparam logic [7:0] SFR_OP_QIO = 8'hEB;
   localparam logic [7:0] SFR_OP_QIO4 = 8'hEC;
   localparam logic [7:0] SFR_OP_QIO_DTR = 8'hED;

   localparam logic [2:0] SFR_W1 = 3'h1;
   localparam logic [2:0] SFR_W2 = 3'h2;
   localparam logic [2:0] SFR_W4 = 3'h4;
   localparam logic [5:0] SFR_CMD_BITS = 6'h08;
   localparam logic [5:0] SFR_BYTE_BITS = 6'h08;
   localparam logic [5:0] SFR_ADDR3_BITS = 6'h18;
   localparam logic [5:0] SFR_ADDR4_BITS = 6'h20;
   localparam int SFR_DUMMY_CYCLES = 8;
   localparam int SFR_SCLK_HALF = 8;
   localparam logic [5:0] SFR_SYNC_RST = 6'h20;

   typedef enum logic [1:0] {SFR_PROTO_EXT, SFR_PROTO_DUAL, SFR_PROTO_QUAD} sfr_proto_e;
   typedef enum logic [2:0] {
      SFR_F_NONE, SFR_F_READ, SFR_F_FAST, SFR_F_DOUT, SFR_F_DIO, SFR_F_QOUT, SFR_F_QIO
   } sfr_fam_e;

   typedef struct packed {
      logic ok;
      logic dtr;
      logic four;
      logic dummy;
      logic dq1;
      logic [2:0] cw;
      logic [2:0] aw;
      logic [2:0] dw;
   } sfr_cmd_s;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] sfr_shift_in(input logic [31:0] v, input logic [3:0] b,
                                                input logic [2:0] w);
      case (w)
         SFR_W2: return {v[29:0], b[1:0]};
         SFR_W4: return {v[27:0], b};
         default: return {v[30:0], b[0]};
      endcase
   endfunction

   function automatic logic [3:0] sfr_top(input logic [31:0] v, input logic [2:0] w);
      case (w)
         SFR_W2: return {2'h0, v[31:30]};
         SFR_W4: return v[31:28];
         default: return {3'h0, v[31]};
      endcase
   endfunction

   function automatic logic [3:0] sfr_mask(input logic [2:0] w);
      case (w)
         SFR_W2: return 4'h3;
         SFR_W4: return 4'hF;
         default: return 4'h1;
      endcase
   endfunction

   function automatic sfr_cmd_s sfr_decode(input logic [7:0] op, input sfr_proto_e proto,
                                           input logic four_mode);
      sfr_cmd_s c;
      sfr_fam_e fam;
      c = '0;
      fam = SFR_F_NONE;
      c.four = four_mode;
      case (op)
         SFR_OP_READ: fam = SFR_F_READ;
         SFR_OP_READ4: begin fam = SFR_F_READ; c.four = 1'b1; end
         SFR_OP_FAST: fam = SFR_F_FAST;
         SFR_OP_FAST4: begin fam = SFR_F_FAST; c.four = 1'b1; end
         SFR_OP_FAST_DTR: begin fam = SFR_F_FAST; c.dtr = 1'b1; end
         SFR_OP_DOUT: fam = SFR_F_DOUT;
         SFR_OP_DOUT4: begin fam = SFR_F_DOUT; c.four = 1'b1; end
         SFR_OP_DOUT_DTR: begin fam = SFR_F_DOUT; c.dtr = 1'b1; end
         SFR_OP_DIO: fam = SFR_F_DIO;
         SFR_OP_DIO4: begin fam = SFR_F_DIO; c.four = 1'b1; end
         SFR_OP_DIO_DTR: begin fam = SFR_F_DIO; c.dtr = 1'b1; end
         SFR_OP_QOUT: fam = SFR_F_QOUT;
         SFR_OP_QOUT4: begin fam = SFR_F_QOUT; c.four = 1'b1; end
         SFR_OP_QOUT_DTR: begin fam = SFR_F_QOUT; c.dtr = 1'b1; end
         SFR_OP_QIO: fam = SFR_F_QIO;
         SFR_OP_QIO4: begin fam = SFR_F_QIO; c.four = 1'b1; end
         SFR_OP_QIO_DTR: begin fam = SFR_F_QIO; c.dtr = 1'b1; end
         default: fam = SFR_F_NONE;
      endcase
      // Lane counts and accepted opcodes depend on protocol
      unique case (proto)
         SFR_PROTO_EXT: begin
            c.ok = fam != SFR_F_NONE;
            c.cw = SFR_W1;
            c.aw = fam == SFR_F_DIO ? SFR_W2 : fam == SFR_F_QIO ? SFR_W4 : SFR_W1;
            c.dw = (fam == SFR_F_READ || fam == SFR_F_FAST) ? SFR_W1 :
                   (fam == SFR_F_DOUT || fam == SFR_F_DIO) ? SFR_W2 : SFR_W4;
         end
         SFR_PROTO_DUAL: begin
            c.ok = fam inside {SFR_F_FAST, SFR_F_DOUT, SFR_F_DIO};
            c.cw = SFR_W2;
            c.aw = SFR_W2;
            c.dw = SFR_W2;
         end
         SFR_PROTO_QUAD: begin
            c.ok = fam inside {SFR_F_FAST, SFR_F_QOUT, SFR_F_QIO};
            c.cw = SFR_W4;
            c.aw = SFR_W4;
            c.dw = SFR_W4;
         end
      endcase
      c.dq1 = proto == SFR_PROTO_EXT && c.dw == SFR_W1;
      c.dummy = fam != SFR_F_READ;
      return c;
   endfunction

endpackage

/* sfr_if.sv */
`timescale 1ns/1ps
interface sfr_if;
   logic cs_n;
   logic sclk;
   logic [3:0] host_drive;
   logic [3:0] host_en;
   logic [3:0] dev_drive;
   logic [3:0] dev_en;
   logic [3:0] data_lanes;

   // Wire level, undriven lanes pulled high
   assign data_lanes = (host_en & host_drive) | (dev_en & dev_drive) | ~(host_en | dev_en);

   modport host (
      output cs_n,
      output sclk,
      output host_drive,
      output host_en,
      input data_lanes
   );
   modport device (
      input cs_n,
      input sclk,
      input data_lanes,
      output dev_drive,
      output dev_en
   );
endinterface

/* sfr_dev.sv */
`timescale 1ns/1ps
module sfr_dev #(
   parameter int MEM_AW = 12,
   parameter int DUMMY = sfr_pkg::SFR_DUMMY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input sfr_pkg::sfr_proto_e proto,
   input wire logic four_byte_mode,
   input wire logic mem_wr_en,
   input wire logic [MEM_AW-1:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   output logic busy,
   output logic refused,
   sfr_if.device link
);
   import sfr_pkg::*;

   typedef enum logic [2:0] {
      SFR_DEV_CMD, SFR_DEV_ADDR, SFR_DEV_DUMMY, SFR_DEV_DATA, SFR_DEV_REJECT
   } sfr_dev_state_e;

   localparam int MEM_DEPTH = 1 << MEM_AW;

   logic [5:0] sync1;
   logic [5:0] sync2;
   logic sclk_prev;
   logic cs_s;
   logic sclk_s;
   logic [3:0] lanes_s;
   logic rise;
   logic fall;

   sfr_dev_state_e state;
   sfr_cmd_s cmd;
   sfr_cmd_s dec;
   logic [5:0] cnt;
   logic [31:0] sh;
   logic [31:0] addr;
   logic [2:0] width;
   logic [31:0] next_sh;
   logic [5:0] next_cnt;
   logic [5:0] addr_bits;
   logic addr_edge;
   logic out_edge;
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] rd_byte;
   logic [31:0] out_word;
   logic [3:0] out_bits;
   logic [3:0] dq_drive;
   logic [3:0] dq_en;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and clock edge detect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= SFR_SYNC_RST;
         sync2 <= SFR_SYNC_RST;
         sclk_prev <= 1'b0;
      end else if (ce) begin
         sync1 <= {link.cs_n, link.sclk, link.data_lanes};
         sync2 <= sync1;
         sclk_prev <= sync2[4];
      end
   end

   assign cs_s = sync2[5];
   assign sclk_s = sync2[4];
   assign lanes_s = sync2[3:0];
   assign rise = sclk_s & ~sclk_prev;
   assign fall = ~sclk_s & sclk_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Shift and count helpers
   always_comb begin
      width = (state == SFR_DEV_CMD) ? sfr_cmd_width(proto) : cmd.aw;
      next_sh = sfr_shift_in(sh, lanes_s, width);
      next_cnt = cnt + {3'h0, width};
      dec = sfr_decode(next_sh[7:0], proto, four_byte_mode);
      addr_bits = cmd.four ? SFR_ADDR4_BITS : SFR_ADDR3_BITS;
      addr_edge = rise | (cmd.dtr & fall);
      out_edge = fall | (cmd.dtr & rise);
   end

   function automatic logic [2:0] sfr_cmd_width(input sfr_proto_e p);
      unique case (p)
         SFR_PROTO_EXT: return SFR_W1;
         SFR_PROTO_DUAL: return SFR_W2;
         SFR_PROTO_QUAD: return SFR_W4;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transaction sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= SFR_DEV_CMD;
         cnt <= 6'h00;
         sh <= 32'h00000000;
         cmd <= '0;
         addr <= 32'h00000000;
      end else if (ce) begin
         if (cs_s) begin
            state <= SFR_DEV_CMD;
            cnt <= 6'h00;
         end else begin
            unique case (state)
               SFR_DEV_CMD: begin
                  if (rise) begin
                     sh <= next_sh;
                     cnt <= next_cnt;
                     if (next_cnt == SFR_CMD_BITS) begin
                        cnt <= 6'h00;
                        cmd <= dec;
                        state <= dec.ok ? SFR_DEV_ADDR : SFR_DEV_REJECT;
                     end
                  end
               end
               SFR_DEV_ADDR: begin
                  if (addr_edge) begin
                     sh <= next_sh;
                     cnt <= next_cnt;
                     if (next_cnt == addr_bits) begin
                        cnt <= 6'h00;
                        addr <= cmd.four ? next_sh : {8'h00, next_sh[23:0]};
                        state <= cmd.dummy ? SFR_DEV_DUMMY : SFR_DEV_DATA;
                     end
                  end
               end
               SFR_DEV_DUMMY: begin
                  if (rise) begin
                     cnt <= cnt + 6'h01;
                     if (cnt + 6'h01 == 6'(DUMMY)) begin
                        cnt <= 6'h00;
                        state <= SFR_DEV_DATA;
                     end
                  end
               end
               SFR_DEV_DATA: begin
                  if (out_edge) begin
                     cnt <= cnt + {3'h0, cmd.dw};
                     if (cnt + {3'h0, cmd.dw} == SFR_BYTE_BITS) begin
                        cnt <= 6'h00;
                        addr <= addr + 32'h00000001;
                     end
                  end
               end
               SFR_DEV_REJECT: begin
                  cnt <= 6'h00;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array and backdoor load
   always_ff @(posedge clk) begin
      if (ce && mem_wr_en) begin
         mem[mem_wr_addr] <= mem_wr_data;
      end
   end

   assign rd_byte = mem[addr[MEM_AW-1:0]];

   always_comb begin
      out_word = {rd_byte, 24'h000000} << cnt;
      out_bits = sfr_top(out_word, cmd.dw);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data lane drive
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_drive <= 4'h0;
         dq_en <= 4'h0;
      end else if (ce) begin
         if (cs_s || state != SFR_DEV_DATA) begin
            dq_en <= 4'h0;
            dq_drive <= 4'h0;
         end else if (out_edge) begin
            if (cmd.dq1) begin
               dq_drive <= {2'h0, out_bits[0], 1'b0};
               dq_en <= 4'h2;
            end else begin
               dq_drive <= out_bits;
               dq_en <= sfr_mask(cmd.dw);
            end
         end
      end
   end

   assign link.dev_drive = dq_drive;
   assign link.dev_en = dq_en;

   ////////////////////////////////////////////////////////////////////////////
   // Status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         refused <= 1'b0;
      end else if (ce) begin
         busy <= ~cs_s;
         refused <= ~cs_s && state == SFR_DEV_REJECT;
      end
   end

endmodule

/* sfr_link_properties.sv */
`timescale 1ns/1ps
module sfr_link_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] host_en,
   input wire logic [3:0] dev_en
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // Serial clock rises since select fell
   logic [7:0] rises;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rises <= 8'h00;
      end else if (cs_n) begin
         rises <= 8'h00;
      end else if ($rose(sclk) && rises != 8'hFF) begin
         rises <= rises + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   cmd_no_drive_a: assert property (!cs_n && rises < 8'h08 |-> dev_en == 4'h0)
      else $error("device drove lanes during command");
   abort_release_a: assert property ($rose(cs_n) |-> ##[0:4] dev_en == 4'h0)
      else $error("device kept driving after select high");
   idle_quiet_a: assert property (cs_n [*5] |-> dev_en == 4'h0)
      else $error("device drove lanes while deselected");
   no_contention_a: assert property ((host_en & dev_en) == 4'h0)
      else $error("both ends drove one lane");
   lane_group_a: assert property (dev_en inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("illegal device lane group");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   clock_in_frame_a: assert property ($changed(sclk) |-> !cs_n)
      else $error("serial clock moved outside frame");
   half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
      else $error("serial clock half period too short");
   host_idle_a: assert property (cs_n [*2] |-> host_en == 4'h0)
      else $error("host drove lanes while deselected");

   cover property (dev_en == 4'h2);
   cover property (dev_en == 4'h3);
   cover property (dev_en == 4'hF);
   cover property (!cs_n && rises == 8'h30);
endmodule

/* serial_flash_four_byte_read_tb_top.sv */
`timescale 1ns/1ps
module serial_flash_four_byte_read_tb_top;
   import sfr_pkg::*;
   typedef struct packed {
      logic [7:0] op;
      sfr_proto_e pr;
      logic fb;
      logic [31:0] ad;
      logic [15:0] n;
      logic rf;
   } sfr_tb_row_s;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [31:0] address = 32'h0;
   logic [15:0] byte_count = 16'h0;
   sfr_proto_e proto = SFR_PROTO_EXT;
   logic four_byte_mode = 1'b0;
   sfr_proto_e dev_proto = SFR_PROTO_EXT;
   logic ce = 1'b1;
   logic dev_seen = 1'b0;
   logic dev_drove = 1'b0;
   logic mem_wr_en = 1'b0;
   logic [11:0] mem_wr_addr = 12'h000;
   logic [7:0] mem_wr_data = 8'h00;
   logic h_busy, h_refused, rd_valid, done, d_busy, d_refused;
   logic [7:0] rd_data;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   sfr_tb_row_s rows [29] = '{
      '{8'h03, SFR_PROTO_EXT, 1'b0, 32'h00000010, 16'h2, 1'b0},
      '{8'h13, SFR_PROTO_EXT, 1'b0, 32'hA5000FFF, 16'h2, 1'b0},
      '{8'h0B, SFR_PROTO_EXT, 1'b1, 32'h00000123, 16'h1, 1'b0},
      '{8'h0C, SFR_PROTO_EXT, 1'b0, 32'h5A000200, 16'h3, 1'b0},
      '{8'h3B, SFR_PROTO_EXT, 1'b0, 32'h00000345, 16'h2, 1'b0},
      '{8'h3C, SFR_PROTO_EXT, 1'b0, 32'h010000FE, 16'h2, 1'b0},
      '{8'hBB, SFR_PROTO_EXT, 1'b1, 32'h00000456, 16'h2, 1'b0},
      '{8'hBC, SFR_PROTO_EXT, 1'b0, 32'h02000567, 16'h2, 1'b0},
      '{8'h6B, SFR_PROTO_EXT, 1'b0, 32'h00000678, 16'h2, 1'b0},
      '{8'h6C, SFR_PROTO_EXT, 1'b0, 32'h03000789, 16'h2, 1'b0},
      '{8'hEB, SFR_PROTO_EXT, 1'b0, 32'h0000089A, 16'h2, 1'b0},
      '{8'hEC, SFR_PROTO_EXT, 1'b0, 32'h040009AB, 16'h3, 1'b0},
      '{8'h0D, SFR_PROTO_EXT, 1'b0, 32'h00000ABC, 16'h2, 1'b0},
      '{8'h3D, SFR_PROTO_EXT, 1'b1, 32'h00000BCD, 16'h2, 1'b0},
      '{8'hBD, SFR_PROTO_EXT, 1'b0, 32'h00000CDE, 16'h2, 1'b0},
      '{8'h6D, SFR_PROTO_EXT, 1'b0, 32'h00000DEF, 16'h2, 1'b0},
      '{8'hED, SFR_PROTO_EXT, 1'b0, 32'h00000EF0, 16'h2, 1'b0},
      '{8'h0B, SFR_PROTO_DUAL, 1'b0, 32'h00000111, 16'h2, 1'b0},
      '{8'h3C, SFR_PROTO_DUAL, 1'b0, 32'h06000222, 16'h2, 1'b0},
      '{8'hBD, SFR_PROTO_DUAL, 1'b1, 32'h00000333, 16'h2, 1'b0},
      '{8'h03, SFR_PROTO_DUAL, 1'b0, 32'h00000444, 16'h1, 1'b1},
      '{8'hEB, SFR_PROTO_DUAL, 1'b0, 32'h00000444, 16'h1, 1'b1},
      '{8'h0C, SFR_PROTO_QUAD, 1'b0, 32'h07000555, 16'h2, 1'b0},
      '{8'h6D, SFR_PROTO_QUAD, 1'b0, 32'h00000666, 16'h2, 1'b0},
      '{8'hEB, SFR_PROTO_QUAD, 1'b1, 32'h00000777, 16'h2, 1'b0},
      '{8'h13, SFR_PROTO_QUAD, 1'b0, 32'h00000444, 16'h1, 1'b1},
      '{8'h3B, SFR_PROTO_QUAD, 1'b0, 32'h00000444, 16'h1, 1'b1},
      '{8'h0B, SFR_PROTO_EXT, 1'b0, 32'h00000100, 16'h0, 1'b1},
      '{8'h9F, SFR_PROTO_EXT, 1'b0, 32'h00000100, 16'h1, 1'b1}
   };

   sfr_if bus();
   sfr_host u_sfr_host (.clk(clk), .rst(rst), .ce(ce), .start(start), .opcode(opcode),
      .address(address), .byte_count(byte_count), .proto(proto),
      .four_byte_mode(four_byte_mode), .busy(h_busy), .refused(h_refused),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .link(bus));
   sfr_dev u_sfr_dev (.clk(clk), .rst(rst), .ce(ce), .proto(dev_proto),
      .four_byte_mode(four_byte_mode), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .busy(d_busy), .refused(d_refused), .link(bus));
   sfr_link_properties u_sfr_link_properties (.clk(clk), .rst(rst), .cs_n(bus.cs_n),
      .sclk(bus.sclk), .host_en(bus.host_en), .dev_en(bus.dev_en));

   ////////////////////////////////////////////////////////////////////////////
   always #12.5 clk = ~clk;

   function automatic logic [7:0] pat(input logic [31:0] a);
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic run(input int r, input bit poke);
      int k;
      int got;
      logic rf;
      got = 0;
      rf = 1'b0;
      @(negedge clk);
      @(negedge clk);
      opcode = rows[r].op;
      proto = rows[r].pr;
      dev_proto = rows[r].pr;
      four_byte_mode = rows[r].fb;
      address = rows[r].ad;
      byte_count = rows[r].n;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (k = 0; k < 6000; k++) begin
         if (h_refused === 1'b1) begin
            rf = 1'b1;
            break;
         end
         if (rd_valid === 1'b1) begin
            check(rd_data, pat(rows[r].ad + got));
            check(d_busy, 1'b1);
            check(h_busy, 1'b1);
            got++;
         end
         if (done === 1'b1) begin
            check(d_busy, 1'b0);
            break;
         end
         @(negedge clk);
         // Busy start and a frozen stretch on the poked run
         start = (poke && k == 40);
         ce = !(poke && k > 40 && k < 60);
      end
      check(32'(k < 6000), 32'h1);
      check(rf, rows[r].rf);
      check(32'(got), rows[r].rf ? 32'h0 : 32'(rows[r].n));
      check(d_refused, 1'b0);
      $display("test %0d done", r);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(negedge clk);
      check(bus.cs_n, 1'b1);
      rst = 1'b0;
      for (int a = 0; a < 4096; a++) begin
         @(negedge clk);
         mem_wr_en = 1'b1;
         mem_wr_addr = a[11:0];
         mem_wr_data = pat(a);
      end
      @(negedge clk);
      mem_wr_en = 1'b0;
      for (int r = 0; r < 29; r++) begin
         run(r, 1'b0);
      end
      // Start while busy is ignored
      run(3, 1'b1);
      // Reset in mid data phase
      @(negedge clk);
      opcode = 8'h0C;
      proto = SFR_PROTO_EXT;
      byte_count = 16'h8;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (900) @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      check(bus.cs_n, 1'b1);
      check(bus.dev_en, 4'h0);
      check(h_busy, 1'b0);
      rst = 1'b0;
      $display("test reset done");
      run(0, 1'b0);
      // Device refuses a code foreign to its protocol
      @(negedge clk);
      dev_proto = SFR_PROTO_QUAD;
      opcode = 8'h03;
      byte_count = 16'h1;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
         dev_seen = dev_seen | (d_refused === 1'b1);
         dev_drove = dev_drove | (bus.dev_en != 4'h0);
         if (rd_valid === 1'b1) begin
            check(rd_data, 8'hFF);
         end
         @(negedge clk);
      end
      check(done, 1'b1);
      check(dev_seen, 1'b1);
      check(dev_drove, 1'b0);
      $display("test refuse done");
      final_report();
   end
endmodule
